// ==== logic/spi_host_shift_engine.sv ====
// SPI shift engine with APB registers, host and client modes.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module spi_host_shift_engine (
  // Clock, reset and clock enable.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Port direction settings and pin levels.
  input  wire spi_host_pkg::spi_lines_s port_dir,
  input  wire logic                    ss_dir,
  input  wire spi_host_pkg::spi_lines_s pin_in,
  input  wire logic                    ss_in_n,
  // Pin drive from the SPI logic.
  output spi_host_pkg::spi_lines_s     pin_level,
  output spi_host_pkg::spi_lines_s     pin_oe,
  // Interrupt requests.
  output logic                         irq_done,
  output logic                         irq_complete
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0]                ctrl_a_reg;
  logic [7:0]                ctrl_b_reg;
  logic [7:0]                irq_ctrl_reg;
  logic [7:0]                shift_reg;
  logic [7:0]                tx_buf_reg;
  logic [7:0]                rx_data_reg;
  logic [7:0]                rx_buf_reg;
  logic [1:0]                rx_count_reg;
  logic [2:0]                bit_cnt_reg;
  logic [6:0]                div_cnt_reg;
  logic                      sck_reg;
  logic                      sample_reg;
  logic                      done_flag_reg;
  logic                      txc_flag_reg;
  logic                      empty_flag_reg;
  logic                      write_collision_flag_flag_reg;
  logic                      sck_s1_reg;
  logic                      sck_s2_reg;
  logic                      sck_s3_reg;
  spi_host_pkg::xfer_state_e state_reg;

  logic                      acc;
  logic                      wr;
  logic                      rd;
  logic                      hit;
  logic                      sel_a;
  logic                      sel_b;
  logic                      sel_ic;
  logic                      sel_if;
  logic                      sel_data;
  logic                      data_wr;
  logic                      enabled;
  logic                      host;
  logic                      client;
  logic                      buf_mode;
  logic                      busy;
  logic                      takeover;
  logic [6:0]                half_len;
  logic                      tick;
  logic                      rise;
  logic                      fall;
  logic                      in_bit;
  logic                      byte_done;
  logic [7:0]                rx_byte;
  logic                      out_bit;
  logic                      load_direct;
  logic                      load_buf;
  logic                      move_buf;
  logic                      pop;
  logic [7:0]                flag_clr;
  logic [31:0]               rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // The slave answers with one wait state; effects happen at the ready edge.
  assign acc      = psel & penable;
  assign wr       = acc & pready & pwrite;
  assign rd       = acc & pready & ~pwrite;
  assign sel_a    = paddr == spi_host_pkg::OFS_CONTROL_A;
  assign sel_b    = paddr == spi_host_pkg::OFS_CONTROL_B;
  assign sel_ic   = paddr == spi_host_pkg::OFS_IRQ_CONTROL;
  assign sel_if   = paddr == spi_host_pkg::OFS_IRQ_FLAG;
  assign sel_data = paddr == spi_host_pkg::OFS_DATA;
  assign hit      = sel_a | sel_b | sel_ic | sel_if | sel_data;
  assign data_wr  = wr & sel_data;
  assign flag_clr = (wr & sel_if) ? pwdata[7:0] : 8'h00;

  // Mode decode; the wait-for-receive bit is stored but unused in both modes.
  assign enabled  = ctrl_a_reg[spi_host_pkg::CA_ENABLE];
  assign host     = enabled & ctrl_a_reg[spi_host_pkg::CA_HOST];
  assign client   = enabled & ~ctrl_a_reg[spi_host_pkg::CA_HOST];
  assign buf_mode = ctrl_b_reg[spi_host_pkg::CB_BUF];
  assign busy     = (state_reg == spi_host_pkg::ST_SHIFT) | (bit_cnt_reg != 3'h0);

  // Another host pulling select low takes the bus from us.
  assign takeover = host & ~ctrl_b_reg[spi_host_pkg::CB_SSD] & ~ss_dir & ~ss_in_n;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock generation and client clock sampling.

  // Doubling halves each prescaler half period; two settings coincide, giving seven.
  assign half_len = ctrl_a_reg[spi_host_pkg::CA_DOUBLE] ?
                    spi_host_pkg::HALF_DOUBLE[ctrl_a_reg[spi_host_pkg::CA_CLOCK_PRESCALER_LO +: 2]] :
                    spi_host_pkg::HALF_NORMAL[ctrl_a_reg[spi_host_pkg::CA_CLOCK_PRESCALER_LO +: 2]];
  assign tick     = (state_reg == spi_host_pkg::ST_SHIFT) & (div_cnt_reg == half_len - 7'h01);

  // Host edges come from the divider, client edges from the synchronised pin.
  always_comb begin
    rise   = 1'b0;
    fall   = 1'b0;
    in_bit = 1'b0;
    if (host) begin
      rise   = tick & ~sck_reg;
      fall   = tick & sck_reg;
      in_bit = pin_in.miso;
    end else if (client & ~ss_in_n) begin
      rise   = sck_s2_reg & ~sck_s3_reg;
      fall   = ~sck_s2_reg & sck_s3_reg;
      in_bit = pin_in.mosi;
    end
  end

  // Shifted value: one bit leaves while one enters, in either order.
  assign rx_byte   = ctrl_a_reg[spi_host_pkg::CA_ORDER] ?
                     {sample_reg, shift_reg[7:1]} : {shift_reg[6:0], sample_reg};
  assign out_bit   = ctrl_a_reg[spi_host_pkg::CA_ORDER] ? shift_reg[0] : shift_reg[7];
  assign byte_done = fall & (bit_cnt_reg == 3'h7);

  // Divider counts half periods only while a host transfer runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 7'h00;
      sck_reg     <= 1'b0;
    end else if (clk_en) begin
      if (load_direct | (state_reg != spi_host_pkg::ST_SHIFT)) begin
        div_cnt_reg <= 7'h00;
        sck_reg     <= 1'b0;
      end else if (tick) begin
        div_cnt_reg <= 7'h00;
        sck_reg     <= ~sck_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
      end
    end
  end

  // Two-stage synchroniser for the incoming client clock, plus edge history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
    end else if (clk_en) begin
      sck_s1_reg <= pin_in.sck;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path.

  // Normal mode writes go straight to the shifter, even mid-byte in host mode,
  // which corrupts the byte on the wire. A busy client ignores them instead.
  always_comb begin
    if (buf_mode) begin
      load_direct = data_wr & empty_flag_reg & (~busy | byte_done);
    end else begin
      load_direct = data_wr & ~(client & busy);
    end
  end
  assign load_buf = data_wr & buf_mode & ~load_direct & empty_flag_reg;
  assign move_buf = byte_done & buf_mode & ~empty_flag_reg;

  // Shift register: software load, buffered byte, or one serial step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg  <= spi_host_pkg::RST_BYTE;
      sample_reg <= 1'b0;
    end else if (clk_en) begin
      if (rise) begin
        sample_reg <= in_bit;
      end
      if (load_direct) begin
        shift_reg <= pwdata[7:0];
      end else if (move_buf) begin
        shift_reg <= tx_buf_reg;
      end else if (fall) begin
        shift_reg <= rx_byte;
      end
    end
  end

  // Transmit buffer holds the second byte of a buffered pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_reg <= spi_host_pkg::RST_BYTE;
    end else if (clk_en && load_buf) begin
      tx_buf_reg <= pwdata[7:0];
    end
  end

  // A later write while the buffer is full is lost; the flag tells software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_flag_reg <= spi_host_pkg::RST_EMPTY;
    end else if (clk_en) begin
      empty_flag_reg <= (empty_flag_reg & ~load_buf) | move_buf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing.

  // Host state: a write starts a byte; a waiting buffered byte chains on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= spi_host_pkg::ST_IDLE;
    end else if (clk_en) begin
      if (!host) begin
        state_reg <= spi_host_pkg::ST_IDLE;
      end else if (load_direct) begin
        state_reg <= spi_host_pkg::ST_SHIFT;
      end else if (byte_done && !move_buf) begin
        state_reg <= spi_host_pkg::ST_IDLE;
      end
    end
  end

  // Bit counter; a client drops a partial byte when deselected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if ((host && load_direct) || (client && ss_in_n) || !enabled) begin
        bit_cnt_reg <= 3'h0;
      end else if (fall) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path.

  // In buffer mode the data register is the head of a two-entry queue. When
  // full, the newest entry is overwritten, so software must keep up.
  assign pop = rd & sel_data & buf_mode & (rx_count_reg != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg  <= spi_host_pkg::RST_BYTE;
      rx_buf_reg   <= spi_host_pkg::RST_BYTE;
      rx_count_reg <= 2'h0;
    end else if (clk_en) begin
      if (!buf_mode) begin
        rx_count_reg <= 2'h0;
        if (byte_done) begin
          rx_data_reg <= rx_byte;
        end
      end else if (byte_done && pop) begin
        if (rx_count_reg == 2'h1) begin
          rx_data_reg <= rx_byte;
        end else begin
          rx_data_reg <= rx_buf_reg;
          rx_buf_reg  <= rx_byte;
        end
      end else if (byte_done) begin
        if (rx_count_reg == 2'h0) begin
          rx_data_reg  <= rx_byte;
          rx_count_reg <= 2'h1;
        end else begin
          rx_buf_reg   <= rx_byte;
          rx_count_reg <= 2'h2;
        end
      end else if (pop) begin
        rx_data_reg  <= rx_buf_reg;
        rx_count_reg <= rx_count_reg - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; hardware set wins over a software clear in the same cycle.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_reg  <= 1'b0;
      txc_flag_reg   <= 1'b0;
      write_collision_flag_flag_reg <= 1'b0;
    end else if (clk_en) begin
      done_flag_reg  <= (done_flag_reg & ~flag_clr[spi_host_pkg::IF_DONE]) |
                        (byte_done & ~buf_mode) | takeover;
      txc_flag_reg   <= (txc_flag_reg & ~flag_clr[spi_host_pkg::IF_TXC]) |
                        (byte_done & buf_mode & ~move_buf & ~load_direct);
      write_collision_flag_flag_reg <= (write_collision_flag_flag_reg & ~flag_clr[spi_host_pkg::IF_WRITE_COLLISION_FLAG]) |
                        (data_wr & ~buf_mode & busy);
    end
  end

  // Requests are gated by their enables; global masking lies outside.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_done     <= 1'b0;
      irq_complete <= 1'b0;
    end else if (clk_en) begin
      irq_done     <= done_flag_reg & irq_ctrl_reg[spi_host_pkg::IC_DONE];
      irq_complete <= txc_flag_reg & irq_ctrl_reg[spi_host_pkg::IC_TXC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Enable is expected last; other fields change behaviour at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg   <= spi_host_pkg::RST_BYTE;
      ctrl_b_reg   <= spi_host_pkg::RST_BYTE;
      irq_ctrl_reg <= spi_host_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (wr && sel_a) begin
        ctrl_a_reg <= pwdata[7:0] & 8'h77;
      end
      if (takeover) begin
        ctrl_a_reg[spi_host_pkg::CA_HOST] <= 1'b0;
      end
      if (wr && sel_b) begin
        ctrl_b_reg <= pwdata[7:0] & 8'hC7;
      end
      if (wr && sel_ic) begin
        irq_ctrl_reg <= pwdata[7:0] & 8'h41;
      end
    end
  end

  // Read mux; the data register always shows the head of the receive side.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      sel_a:    rd_mux[7:0] = ctrl_a_reg;
      sel_b:    rd_mux[7:0] = ctrl_b_reg;
      sel_ic:   rd_mux[7:0] = irq_ctrl_reg;
      sel_if:   rd_mux[7:0] = {done_flag_reg, txc_flag_reg, empty_flag_reg, write_collision_flag_flag_reg, 4'h0};
      sel_data: rd_mux[7:0] = rx_data_reg;
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait state, error on an unmapped offset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready) begin
        prdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership; a disabled engine leaves every pin to the port logic.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= '0;
      pin_oe    <= '0;
    end else if (clk_en) begin
      pin_level.sck  <= sck_reg;
      pin_level.mosi <= out_bit;
      pin_level.miso <= out_bit;
      pin_oe.sck     <= host & port_dir.sck;
      pin_oe.mosi    <= host & port_dir.mosi;
      pin_oe.miso    <= client & port_dir.miso & ~ss_in_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_buf_push;
    clk_en && byte_done && buf_mode && !pop && rx_count_reg == 2'h0;
  endsequence

  sequence s_buf_queue;
    clk_en && load_buf;
  endsequence

  a_write_starts_host: assert property (clk_en && host && load_direct |=>
    state_reg == spi_host_pkg::ST_SHIFT && bit_cnt_reg == 3'h0)
    else $error("Host write did not start a transfer.");
  a_early_collision: assert property (clk_en && data_wr && !buf_mode && busy |=> write_collision_flag_flag_reg)
    else $error("Early write did not flag a collision.");
  a_normal_capture: assert property (clk_en && byte_done && !buf_mode |=>
    rx_data_reg == $past(rx_byte) && done_flag_reg)
    else $error("Normal byte not captured with done flag.");
  a_queue_push: assert property (s_buf_push |=> rx_count_reg == 2'h1 && rx_data_reg == $past(rx_byte))
    else $error("Buffered byte not pushed to queue.");
  a_buffer_hold: assert property (s_buf_queue |=> !empty_flag_reg && tx_buf_reg == $past(pwdata[7:0]))
    else $error("Buffered write not held.");
  a_complete_flag: assert property (clk_en && byte_done && buf_mode && empty_flag_reg && !data_wr |=>
    txc_flag_reg)
    else $error("Complete flag not set.");
  a_takeover_client: assert property (clk_en && takeover |=>
    !ctrl_a_reg[spi_host_pkg::CA_HOST] && done_flag_reg)
    else $error("Select takeover did not drop host mode.");
  a_miso_tristate: assert property (clk_en && ss_in_n |=> !pin_oe.miso)
    else $error("MISO driven while deselected.");
  a_client_inputs: assert property (clk_en && client |=> !pin_oe.mosi && !pin_oe.sck)
    else $error("Client drove a forced input.");

endmodule // spi_host_shift_engine

// ==== shared/spi_host_pkg.sv ====
// Constants, register layout and carrier types of the SPI shift engine.
package spi_host_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_CONTROL_A   = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B   = 8'h04;
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAG    = 8'h0C;
  localparam logic [7:0] OFS_DATA        = 8'h10;

  // Field positions in control_a.
  localparam int CA_ENABLE   = 0;
  localparam int CA_CLOCK_PRESCALER_LO = 1;
  localparam int CA_DOUBLE   = 4;
  localparam int CA_HOST     = 5;
  localparam int CA_ORDER    = 6;

  // Field positions in control_b.
  localparam int CB_MODE_LO = 0;
  localparam int CB_SSD     = 2;
  localparam int CB_WAIT    = 6;
  localparam int CB_BUF     = 7;

  // Field positions in irq_control and irq_flag.
  localparam int IC_DONE  = 0;
  localparam int IC_TXC   = 6;
  localparam int IF_DONE  = 7;
  localparam int IF_TXC   = 6;
  localparam int IF_EMPTY = 5;
  localparam int IF_WRITE_COLLISION_FLAG = 4;

  // Reset values.
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic       RST_EMPTY = 1'b1;

  // Half SCK periods in pclk cycles, indexed by clock_prescaler.
  localparam logic [3:0][6:0] HALF_NORMAL = {7'h40, 7'h20, 7'h08, 7'h02};
  localparam logic [3:0][6:0] HALF_DOUBLE = {7'h20, 7'h10, 7'h04, 7'h01};

  // Transfer states.
  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} xfer_state_e;

  // One bit for each of the three SPI data and clock lines.
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spi_lines_s;

endpackage

// ==== tb/spi_client_model.sv ====
// SPI client model for the engine's far side, mode 0, MSB first.
`timescale 1ns/1ps
module spi_client_model (
  // Bus lines.
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // Byte seen last and first byte to send.
  input  wire logic [7:0] tx_base,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic [7:0] nbytes = 8'h00;
  logic       lat = 1'b0;
  logic       last = 1'b0;
  ////////////////////////////////////////////////////////////
  // A frame starts when the host selects us; each byte sent grows by one.
  always @(negedge sel_n) begin
    sh = tx_base;
    cnt = 3'h0;
    nbytes = 8'h01;
  end
  // Sample the host line on the rise, shift on the fall.
  always @(posedge sck) begin
    lat = mosi;
  end
  always @(negedge sck) begin
    sh = {sh[6:0], lat};
    cnt = cnt + 3'h1;
    if (cnt == 3'h0) begin
      rx_byte = sh;
      sh = tx_base + nbytes;
      nbytes = nbytes + 8'h01;
    end
  end
  // A deselected line shows the inverse of its last level, so a stale bit never passes.
  always @(posedge sel_n) begin
    last = ~sh[7];
  end
  assign miso = sel_n ? last : sh[7];
endmodule // spi_client_model

// ==== tb/spi_host_shift_engine_test.sv ====
// Self-checking bench for the SPI shift engine with a client model.
`timescale 1ns/1ps
module spi_host_shift_engine_test;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0000_0000;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     ss_dir = 1'b1;
  logic                     ss_in_n = 1'b1;
  logic                     sel_n = 1'b1;
  logic                     miso;
  logic                     irq_done;
  logic                     irq_complete;
  logic [7:0]               tx_base = 8'h00;
  logic [7:0]               rx_byte;
  logic [31:0]              rd;
  logic [31:0]              err;
  spi_host_pkg::spi_lines_s pin_level;
  spi_host_pkg::spi_lines_s pin_oe;
  spi_host_pkg::spi_lines_s pin_in;
  spi_host_pkg::spi_lines_s port_dir = 3'b110;
  int                       error_cnt = 0;
  int                       check_count = 0;
  int                       hi;
  always #2.5 pclk = ~pclk;
  // Wire levels follow whoever drives each line.
  assign pin_in = '{sck: pin_oe.sck & pin_level.sck, mosi: pin_oe.mosi & pin_level.mosi,
                    miso: pin_oe.miso ? pin_level.miso : miso};
  spi_host_shift_engine spi_host_shift_engine_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_dir(port_dir), .ss_dir(ss_dir), .pin_in(pin_in), .ss_in_n(ss_in_n),
    .pin_level(pin_level), .pin_oe(pin_oe), .irq_done(irq_done), .irq_complete(irq_complete));
  spi_client_model spi_client_model_i (.sck(pin_level.sck), .mosi(pin_level.mosi), .sel_n(sel_n), .miso(miso),
    .tx_base(tx_base), .rx_byte(rx_byte));
  ////////////////////////////////////////////////////////////
  // Compare, report and close.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin
        error_cnt++;
        close_out();
      end
    end while (pready !== 1'b1);
    // Answer taken at the ready edge; the request drops at that same edge.
    rd = prdata;
    err = {31'h0000_0000, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for an interrupt line while counting cycles with SCK high.
  task automatic wait_irq(input logic cmp);
    int n;
    n = 0;
    hi = 0;
    do begin
      @(negedge pclk);
      hi += pin_level.sck;
      n++;
      if (n > 4000) begin
        error_cnt++;
        close_out();
      end
    end while ((cmp ? irq_complete : irq_done) !== 1'b1);
  endtask
  // Enable goes last so no half-set mode ever runs.
  task automatic cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ic);
    apb(1'b1, spi_host_pkg::OFS_CONTROL_A, 8'h00);
    apb(1'b1, spi_host_pkg::OFS_CONTROL_B, cb);
    apb(1'b1, spi_host_pkg::OFS_IRQ_CONTROL, ic);
    apb(1'b1, spi_host_pkg::OFS_IRQ_FLAG, 8'hF0);
    apb(1'b1, spi_host_pkg::OFS_CONTROL_A, ca);
  endtask
  // One selected byte exchange; the received byte is read before the next one ends.
  task automatic xfer(input logic [7:0] d);
    sel_n <= 1'b0;
    apb(1'b1, spi_host_pkg::OFS_DATA, d);
    wait_irq(1'b0);
    sel_n <= 1'b1;
    apb(1'b0, spi_host_pkg::OFS_DATA, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, spi_host_pkg::OFS_IRQ_FLAG, 8'h00);
    check(rd, 32'h0000_0001 << spi_host_pkg::IF_EMPTY);
    apb(1'b0, 8'h14, 8'h00);
    check(err, 32'h0000_0001);
    $display("test reset done");
    tx_base <= 8'h3C;
    cfg(8'h21, 8'h04, 8'h01);
    xfer(8'hA5);
    check(rd, 32'h0000_003C);
    check({24'h00_0000, rx_byte}, 32'h0000_00A5);
    check({29'h0000_0000, pin_oe}, 32'h0000_0006);
    apb(1'b0, spi_host_pkg::OFS_IRQ_FLAG, 8'h00);
    check(rd & 32'h0000_0080, 32'h0000_0080);
    tx_base <= 8'h12;
    cfg(8'h61, 8'h04, 8'h01);
    xfer(8'h01);
    check(rd, 32'h0000_0048);
    check({24'h00_0000, rx_byte}, 32'h0000_0080);
    $display("test normal done");
    cfg(8'h21, 8'h04, 8'h01);
    sel_n <= 1'b0;
    apb(1'b1, spi_host_pkg::OFS_DATA, 8'h55);
    xfer(8'h66);
    apb(1'b0, spi_host_pkg::OFS_IRQ_FLAG, 8'h00);
    check(rd & 32'h0000_0010, 32'h0000_0010);
    $display("test collision done");
    for (int p = 0; p < 8; p++) begin
      cfg(8'h21 | 8'(p % 4) << 1 | 8'(p / 4) << 4, 8'h04, 8'h01);
      xfer(8'hC3);
      check(hi, 8 * (p / 4 ? spi_host_pkg::HALF_DOUBLE[p % 4] : spi_host_pkg::HALF_NORMAL[p % 4]));
    end
    $display("test rates done");
    tx_base <= 8'h70;
    cfg(8'h21, 8'hC4, 8'h41);
    sel_n <= 1'b0;
    apb(1'b1, spi_host_pkg::OFS_DATA, 8'h11);
    apb(1'b1, spi_host_pkg::OFS_DATA, 8'h22);
    wait_irq(1'b1);
    sel_n <= 1'b1;
    check({24'h00_0000, rx_byte}, 32'h0000_0022);
    apb(1'b0, spi_host_pkg::OFS_IRQ_FLAG, 8'h00);
    check(rd & 32'h0000_0060, 32'h0000_0060);
    apb(1'b0, spi_host_pkg::OFS_DATA, 8'h00);
    check(rd, 32'h0000_0070);
    apb(1'b0, spi_host_pkg::OFS_DATA, 8'h00);
    check(rd, 32'h0000_0071);
    $display("test buffer done");
    cfg(8'h21, 8'h00, 8'h01);
    port_dir <= 3'b111;
    ss_dir <= 1'b0;
    ss_in_n <= 1'b0;
    apb(1'b0, spi_host_pkg::OFS_CONTROL_A, 8'h00);
    check(rd & 32'h0000_0020, 32'h0000_0000);
    apb(1'b0, spi_host_pkg::OFS_IRQ_FLAG, 8'h00);
    check(rd & 32'h0000_0080, 32'h0000_0080);
    check({29'h0000_0000, pin_oe}, 32'h0000_0001);
    ss_in_n <= 1'b1;
    apb(1'b0, spi_host_pkg::OFS_CONTROL_A, 8'h00);
    check(rd & 32'h0000_0020, 32'h0000_0000);
    check({29'h0000_0000, pin_oe}, 32'h0000_0000);
    $display("test takeover done");
    close_out();
  end
endmodule // spi_host_shift_engine_test
